/* File: rtl/urs_consts.vh */
`ifndef URS_CONSTS_VH
`define URS_CONSTS_VH
// register locations on the three address lines
`define URS_LOC_DATA 3'h0
`define URS_LOC_IEN 3'h1
`define URS_LOC_FIFO 3'h2
`define URS_LOC_LINE 3'h3
`define URS_LOC_MODEM 3'h4
`define URS_LOC_LSTAT 3'h5
`define URS_LOC_MSTAT 3'h6
`define URS_LOC_SCR 3'h7
// gating values and field positions
`define URS_LCR_ENH_KEY 8'hbf
`define URS_LCR_DIV_BIT 7
`define URS_EFR_ENH_BIT 4
`define URS_MCR_LVL_BIT 6
`define URS_MCR_LOOP_BIT 4
`define URS_MCR_RDY_BIT 2
// enhanced-only bits masks
`define URS_IER_ENH_MASK 8'hf0
`define URS_FCR_ENH_MASK 8'h30
`define URS_MCR_ENH_MASK 8'he0
// fifo ready view: bits 7:6 and 3:2 always read as zero
`define URS_RDY_MASK 8'h33
// reset value of all stored bytes (none documented)
`define URS_RESET_BYTE 8'h00
// strobe synchroniser depth
`define URS_SYNC_STAGES 2
`endif

/* File: rtl/urs_register_select_map.v */
`include "urs_consts.vh"

module urs_register_select_map (
    input wire clk_in,
    input wire nrst_in,
    input wire [2:0] addr_in,
    input wire channel_a_select_n_in,
    input wire channel_b_select_n_in,
    input wire rd_n_in,
    input wire wr_n_in,
    input wire [7:0] wdata_in,
    input wire [7:0] rx_byte_in,
    input wire [7:0] ident_in,
    input wire [7:0] line_state_in,
    input wire [7:0] modem_state_in,
    input wire [7:0] fifo_ready_in,
    output reg [7:0] rdata_out,
    output reg rdata_oe_out,
    output reg rx_pop_out,
    output reg tx_push_out,
    output reg [7:0] tx_byte_out,
    output reg fifo_ctrl_wr_out,
    output reg [7:0] fifo_control_out,
    output reg [7:0] interrupt_enables_out,
    output reg [7:0] line_format_control_out,
    output reg [7:0] modem_control_out,
    output reg [15:0] baud_divisor_out,
    output reg [7:0] enhanced_features_out,
    output reg [7:0] resume_char_one_out,
    output reg [7:0] resume_char_two_out,
    output reg [7:0] pause_char_one_out,
    output reg [7:0] pause_char_two_out,
    output reg [7:0] flow_halt_resume_levels_out,
    output reg [7:0] fifo_threshold_levels_out
);

    // decoded register targets
    localparam SEL_NONE = 4'h0;
    localparam SEL_DATA = 4'h1;
    localparam SEL_IEN = 4'h2;
    localparam SEL_FIFO = 4'h3;
    localparam SEL_LINE = 4'h4;
    localparam SEL_MODEM = 4'h5;
    localparam SEL_LSTAT = 4'h6;
    localparam SEL_MSTAT = 4'h7;
    localparam SEL_SCR = 4'h8;
    localparam SEL_DLL = 4'h9;
    localparam SEL_DLH = 4'ha;
    localparam SEL_EFR = 4'hb;
    localparam SEL_RESUME_CHAR_ONE = 4'hc;
    localparam SEL_RESUME_CHAR_TWO = 4'hd;
    localparam SEL_PAUSE_CHAR_ONE = 4'he;
    localparam SEL_PAUSE_CHAR_TWO = 4'hf;
    localparam SEL_TCR = 5'h10;
    localparam SEL_TLR = 5'h11;
    localparam SEL_RDY = 5'h12;

    // host pins are asynchronous: two flops before any logic
    reg [2:0] addr_s1_ff;
    reg [2:0] addr_s2_ff;
    reg csa_s1_ff;
    reg csa_s2_ff;
    reg csb_s1_ff;
    reg csb_s2_ff;
    reg rd_s1_ff;
    reg rd_s2_ff;
    reg wr_s1_ff;
    reg wr_s2_ff;
    reg [7:0] wd_s1_ff;
    reg [7:0] wd_s2_ff;
    reg rd_dly_ff;
    reg wr_dly_ff;
    reg [7:0] scratch_ff;

    wire any_sel = ~csa_s2_ff | ~csb_s2_ff;
    wire both_sel = ~csa_s2_ff & ~csb_s2_ff;
    wire rd_act = ~rd_s2_ff & any_sel;
    wire wr_act = ~wr_s2_ff & any_sel;
    // one access per strobe: act on the leading edge only
    wire rd_start = rd_act & ~rd_dly_ff;
    wire wr_start = wr_act & ~wr_dly_ff;

    wire lvl_en = enhanced_features_out[`URS_EFR_ENH_BIT] &
        modem_control_out[`URS_MCR_LVL_BIT];
    wire rdy_en = both_sel & modem_control_out[`URS_MCR_RDY_BIT] &
        ~modem_control_out[`URS_MCR_LOOP_BIT];
    wire enh_on = enhanced_features_out[`URS_EFR_ENH_BIT];

    // address decode shared by read and write paths
    function [4:0] decode;
        input [2:0] loc;
        input is_rd;
        input [7:0] line_format_control;
        input lvl;
        input rdy;
        begin
            decode = {1'b0, SEL_NONE};
            if (line_format_control == `URS_LCR_ENH_KEY)
            begin
                case (loc)
                    `URS_LOC_DATA: decode = {1'b0, SEL_DLL};
                    `URS_LOC_IEN: decode = {1'b0, SEL_DLH};
                    `URS_LOC_FIFO: decode = {1'b0, SEL_EFR};
                    `URS_LOC_LINE: decode = {1'b0, SEL_LINE};
                    `URS_LOC_MODEM: decode = {1'b0, SEL_RESUME_CHAR_ONE};
                    `URS_LOC_LSTAT: decode = {1'b0, SEL_RESUME_CHAR_TWO};
                    `URS_LOC_MSTAT: decode = {1'b0, SEL_PAUSE_CHAR_ONE};
                    default: decode = {1'b0, SEL_PAUSE_CHAR_TWO};
                endcase
            end
            else if (lvl && loc == `URS_LOC_MSTAT)
                decode = SEL_TCR;
            else if (lvl && loc == `URS_LOC_SCR)
                decode = SEL_TLR;
            else if (is_rd && rdy && loc == `URS_LOC_SCR)
                decode = SEL_RDY;
            else if (line_format_control[`URS_LCR_DIV_BIT] && loc == `URS_LOC_DATA)
                decode = {1'b0, SEL_DLL};
            else if (line_format_control[`URS_LCR_DIV_BIT] && loc == `URS_LOC_IEN)
                decode = {1'b0, SEL_DLH};
            else
            begin
                case (loc)
                    `URS_LOC_DATA: decode = {1'b0, SEL_DATA};
                    `URS_LOC_IEN: decode = {1'b0, SEL_IEN};
                    `URS_LOC_FIFO: decode = {1'b0, SEL_FIFO};
                    `URS_LOC_LINE: decode = {1'b0, SEL_LINE};
                    `URS_LOC_MODEM: decode = {1'b0, SEL_MODEM};
                    `URS_LOC_LSTAT: decode = {1'b0, SEL_LSTAT};
                    `URS_LOC_MSTAT: decode = {1'b0, SEL_MSTAT};
                    default: decode = {1'b0, SEL_SCR};
                endcase
            end
        end
    endfunction

    // keep protected bits unless enhanced mode allows the write
    function [7:0] guard;
        input [7:0] old;
        input [7:0] nw;
        input [7:0] mask;
        input en;
        begin
            guard = en ? nw : ((old & mask) | (nw & ~mask));
        end
    endfunction

    wire [4:0] rsel = decode(addr_s2_ff, 1'b1, line_format_control_out,
        lvl_en, rdy_en);
    wire [4:0] wsel = decode(addr_s2_ff, 1'b0, line_format_control_out,
        lvl_en, rdy_en);

    reg [7:0] nxt_rdata;
    always @*
    begin
        case (rsel)
            {1'b0, SEL_DATA}: nxt_rdata = rx_byte_in;
            {1'b0, SEL_IEN}: nxt_rdata = interrupt_enables_out;
            {1'b0, SEL_FIFO}: nxt_rdata = ident_in;
            {1'b0, SEL_LINE}: nxt_rdata = line_format_control_out;
            {1'b0, SEL_MODEM}: nxt_rdata = modem_control_out;
            {1'b0, SEL_LSTAT}: nxt_rdata = line_state_in;
            {1'b0, SEL_MSTAT}: nxt_rdata = modem_state_in;
            {1'b0, SEL_SCR}: nxt_rdata = scratch_ff;
            {1'b0, SEL_DLL}: nxt_rdata = baud_divisor_out[7:0];
            {1'b0, SEL_DLH}: nxt_rdata = baud_divisor_out[15:8];
            {1'b0, SEL_EFR}: nxt_rdata = enhanced_features_out;
            {1'b0, SEL_RESUME_CHAR_ONE}: nxt_rdata = resume_char_one_out;
            {1'b0, SEL_RESUME_CHAR_TWO}: nxt_rdata = resume_char_two_out;
            {1'b0, SEL_PAUSE_CHAR_ONE}: nxt_rdata = pause_char_one_out;
            {1'b0, SEL_PAUSE_CHAR_TWO}: nxt_rdata = pause_char_two_out;
            SEL_TCR: nxt_rdata = flow_halt_resume_levels_out;
            SEL_TLR: nxt_rdata = fifo_threshold_levels_out;
            SEL_RDY: nxt_rdata = fifo_ready_in & `URS_RDY_MASK;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            addr_s1_ff <= 3'h0;
            addr_s2_ff <= 3'h0;
            csa_s1_ff <= 1'b1;
            csa_s2_ff <= 1'b1;
            csb_s1_ff <= 1'b1;
            csb_s2_ff <= 1'b1;
            rd_s1_ff <= 1'b1;
            rd_s2_ff <= 1'b1;
            wr_s1_ff <= 1'b1;
            wr_s2_ff <= 1'b1;
            wd_s1_ff <= 8'h00;
            wd_s2_ff <= 8'h00;
        end
        else
        begin
            addr_s1_ff <= addr_in;
            addr_s2_ff <= addr_s1_ff;
            csa_s1_ff <= channel_a_select_n_in;
            csa_s2_ff <= csa_s1_ff;
            csb_s1_ff <= channel_b_select_n_in;
            csb_s2_ff <= csb_s1_ff;
            rd_s1_ff <= rd_n_in;
            rd_s2_ff <= rd_s1_ff;
            wr_s1_ff <= wr_n_in;
            wr_s2_ff <= wr_s1_ff;
            wd_s1_ff <= wdata_in;
            wd_s2_ff <= wd_s1_ff;
        end
    end

    // one write enable per storage target
    wire wr_tx = wr_start && wsel == {1'b0, SEL_DATA};
    wire wr_ien = wr_start && wsel == {1'b0, SEL_IEN};
    wire wr_fcr = wr_start && wsel == {1'b0, SEL_FIFO};
    wire wr_lcr = wr_start && wsel == {1'b0, SEL_LINE};
    wire wr_mcr = wr_start && wsel == {1'b0, SEL_MODEM};
    wire wr_scr = wr_start && wsel == {1'b0, SEL_SCR};
    wire wr_dll = wr_start && wsel == {1'b0, SEL_DLL};
    wire wr_dlh = wr_start && wsel == {1'b0, SEL_DLH};
    wire wr_efr = wr_start && wsel == {1'b0, SEL_EFR};
    wire wr_resume_char_one = wr_start && wsel == {1'b0, SEL_RESUME_CHAR_ONE};
    wire wr_resume_char_two = wr_start && wsel == {1'b0, SEL_RESUME_CHAR_TWO};
    wire wr_pause_char_one = wr_start && wsel == {1'b0, SEL_PAUSE_CHAR_ONE};
    wire wr_pause_char_two = wr_start && wsel == {1'b0, SEL_PAUSE_CHAR_TWO};
    wire wr_tcr = wr_start && wsel == SEL_TCR;
    wire wr_tlr = wr_start && wsel == SEL_TLR;
    // status locations get no enable: writes change nothing; a write at the fifo ready location lands in scratch

    // read path: one pop per strobe, so a long strobe never drains two bytes
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rd_dly_ff <= 1'b0;
            rdata_out <= 8'h00;
            rdata_oe_out <= 1'b0;
            rx_pop_out <= 1'b0;
        end
        else
        begin
            rd_dly_ff <= rd_act;
            // enable trails the pin strobe by the two synchroniser flops plus its own register
            rdata_oe_out <= rd_act;
            if (rd_start)
                rdata_out <= nxt_rdata;
            rx_pop_out <= rd_start && rsel == {1'b0, SEL_DATA};
        end
    end

    // pulses and the write-only bytes towards the engine
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wr_dly_ff <= 1'b0;
            tx_push_out <= 1'b0;
            tx_byte_out <= `URS_RESET_BYTE;
            fifo_ctrl_wr_out <= 1'b0;
            fifo_control_out <= `URS_RESET_BYTE;
        end
        else
        begin
            wr_dly_ff <= wr_act;
            tx_push_out <= wr_tx;
            fifo_ctrl_wr_out <= wr_fcr;
            if (wr_tx)
                tx_byte_out <= wd_s2_ff;
            if (wr_fcr)
                fifo_control_out <= guard(fifo_control_out, wd_s2_ff,
                    `URS_FCR_ENH_MASK, enh_on);
        end
    end

    // host-visible storage
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            // no reset value is documented: everything clears to zero
            interrupt_enables_out <= `URS_RESET_BYTE;
            line_format_control_out <= `URS_RESET_BYTE;
            modem_control_out <= `URS_RESET_BYTE;
            baud_divisor_out <= 16'h0000;
            enhanced_features_out <= `URS_RESET_BYTE;
            resume_char_one_out <= `URS_RESET_BYTE;
            resume_char_two_out <= `URS_RESET_BYTE;
            pause_char_one_out <= `URS_RESET_BYTE;
            pause_char_two_out <= `URS_RESET_BYTE;
            flow_halt_resume_levels_out <= `URS_RESET_BYTE;
            fifo_threshold_levels_out <= `URS_RESET_BYTE;
            scratch_ff <= `URS_RESET_BYTE;
        end
        else
        begin
            // protected bits keep their value while enhanced mode is off
            if (wr_ien)
                interrupt_enables_out <= guard(interrupt_enables_out,
                    wd_s2_ff, `URS_IER_ENH_MASK, enh_on);
            if (wr_lcr)
                line_format_control_out <= wd_s2_ff;
            if (wr_mcr)
                modem_control_out <= guard(modem_control_out, wd_s2_ff,
                    `URS_MCR_ENH_MASK, enh_on);
            if (wr_scr)
                scratch_ff <= wd_s2_ff;
            if (wr_dll)
                baud_divisor_out[7:0] <= wd_s2_ff;
            if (wr_dlh)
                baud_divisor_out[15:8] <= wd_s2_ff;
            if (wr_efr)
                enhanced_features_out <= wd_s2_ff;
            if (wr_resume_char_one)
                resume_char_one_out <= wd_s2_ff;
            if (wr_resume_char_two)
                resume_char_two_out <= wd_s2_ff;
            if (wr_pause_char_one)
                pause_char_one_out <= wd_s2_ff;
            if (wr_pause_char_two)
                pause_char_two_out <= wd_s2_ff;
            if (wr_tcr)
                flow_halt_resume_levels_out <= wd_s2_ff;
            if (wr_tlr)
                fifo_threshold_levels_out <= wd_s2_ff;
        end
    end

endmodule // urs_register_select_map

/* File: sim/urs_asserts.sv */
module urs_asserts (
    input wire clk_in,
    input wire nrst_in,
    input wire [2:0] addr_in,
    input wire channel_a_select_n_in,
    input wire rd_n_in,
    input wire wr_n_in,
    input wire [7:0] wdata_in,
    input wire rdata_oe_out,
    input wire tx_push_out,
    input wire [7:0] tx_byte_out,
    input wire fifo_ctrl_wr_out,
    input wire [7:0] interrupt_enables_out,
    input wire [7:0] line_format_control_out,
    input wire [7:0] modem_control_out,
    input wire [15:0] baud_divisor_out,
    input wire [7:0] enhanced_features_out,
    input wire [7:0] flow_halt_resume_levels_out
);
    timeunit 1ns;
    timeprecision 1ps;
    reg wr_q_ff;
    reg rd_q_ff;
    wire [7:0] line_format_control = line_format_control_out;
    wire key = line_format_control == 8'hbf;
    wire lvl = enhanced_features_out[4] & modem_control_out[6];
    // write strobe leading edge, as the pins show it
    wire wf = wr_q_ff & !wr_n_in & !channel_a_select_n_in;
    wire rf = rd_q_ff & !rd_n_in & !channel_a_select_n_in;
    always @(posedge clk_in or negedge nrst_in)
        if (!nrst_in)
        begin
            wr_q_ff <= 1'b1;
            rd_q_ff <= 1'b1;
        end
        else
        begin
            wr_q_ff <= wr_n_in;
            rd_q_ff <= rd_n_in;
        end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // synchroniser lets the update land on the second or third edge
    property p_push;
        wf && addr_in == 3'h0 && !key && !line_format_control[7]
            |-> ##[2:3] tx_push_out && tx_byte_out == wdata_in;
    endproperty
    a_push: assert property (p_push) else $error("push");
    property p_fcr;
        wf && addr_in == 3'h2 && !key |-> ##[2:3] fifo_ctrl_wr_out;
    endproperty
    a_fcr: assert property (p_fcr) else $error("fifo ctl");
    property p_lcr;
        wf && addr_in == 3'h3 |-> ##[2:3] line_format_control == wdata_in;
    endproperty
    a_lcr: assert property (p_lcr) else $error("lcr");
    property p_ro;
        wf && addr_in == 3'h5 && !key |=> ($stable(modem_control_out)
            && $stable(interrupt_enables_out))[*4];
    endproperty
    a_ro: assert property (p_ro) else $error("read only");
    property p_div;
        wf && addr_in == 3'h1 && !key && line_format_control[7]
            |-> ##[2:3] baud_divisor_out[15:8] == wdata_in;
    endproperty
    a_div: assert property (p_div) else $error("divisor");
    property p_efr;
        wf && addr_in == 3'h2 && key
            |-> ##[2:3] enhanced_features_out == wdata_in;
    endproperty
    a_efr: assert property (p_efr) else $error("efr");
    property p_tcr;
        wf && addr_in == 3'h6 && !key && lvl
            |-> ##[2:3] flow_halt_resume_levels_out == wdata_in;
    endproperty
    a_tcr: assert property (p_tcr) else $error("levels");
    property p_ier;
        wf && addr_in == 3'h1 && !key && !line_format_control[7] && !enhanced_features_out[4]
            |=> $stable(interrupt_enables_out[7:4])[*4];
    endproperty
    a_ier: assert property (p_ier) else $error("ier enh");
    property p_oe;
        rf |-> ##[2:3] rdata_oe_out;
    endproperty
    a_oe: assert property (p_oe) else $error("read enable");
endmodule // urs_asserts

bind urs_register_select_map urs_asserts i_urs_asserts (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .addr_in(addr_in),
    .channel_a_select_n_in(channel_a_select_n_in),
    .rd_n_in(rd_n_in),
    .wr_n_in(wr_n_in),
    .wdata_in(wdata_in),
    .rdata_oe_out(rdata_oe_out),
    .tx_push_out(tx_push_out),
    .tx_byte_out(tx_byte_out),
    .fifo_ctrl_wr_out(fifo_ctrl_wr_out),
    .interrupt_enables_out(interrupt_enables_out),
    .line_format_control_out(line_format_control_out),
    .modem_control_out(modem_control_out),
    .baud_divisor_out(baud_divisor_out),
    .enhanced_features_out(enhanced_features_out),
    .flow_halt_resume_levels_out(flow_halt_resume_levels_out)
);

/* File: sim/urs_engine_model.sv */
module urs_engine_model (
    input wire clk_in,
    input wire nrst_in,
    input wire rx_pop_in,
    output logic [7:0] rx_byte_out = 8'h5a
);
    timeunit 1ns;
    timeprecision 1ps;
    // a pop moves on to the next queued byte; transmit side is separate
    always @(negedge clk_in or negedge nrst_in)
        if (!nrst_in)
            rx_byte_out <= 8'h5a;
        else if (rx_pop_in)
            rx_byte_out <= rx_byte_out + 8'h35;
endmodule // urs_engine_model

/* File: sim/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, nrst_in = 0, rd_n_in = 1, wr_n_in = 1;
    logic channel_a_select_n_in = 1, channel_b_select_n_in = 1;
    logic [2:0] addr_in = 0;
    logic [7:0] wdata_in = 0, ident_in, line_state_in, modem_state_in;
    logic [7:0] fifo_ready_in, rx_byte_in, rdata_out, tx_byte_out;
    logic [7:0] fifo_control_out, interrupt_enables_out, modem_control_out;
    logic [7:0] line_format_control_out, enhanced_features_out;
    logic [7:0] resume_char_one_out, resume_char_two_out, pause_char_one_out;
    logic [7:0] pause_char_two_out, flow_halt_resume_levels_out;
    logic [7:0] fifo_threshold_levels_out, r, s, m, q;
    logic [15:0] baud_divisor_out;
    logic rdata_oe_out, rx_pop_out, tx_push_out, fifo_ctrl_wr_out;
    logic [31:0] seed = 32'd83513;
    int mismatches = 0, n_tests = 0;
    urs_register_select_map i_urs_register_select_map (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .addr_in(addr_in),
        .channel_a_select_n_in(channel_a_select_n_in),
        .channel_b_select_n_in(channel_b_select_n_in),
        .rd_n_in(rd_n_in),
        .wr_n_in(wr_n_in),
        .wdata_in(wdata_in),
        .rx_byte_in(rx_byte_in),
        .ident_in(ident_in),
        .line_state_in(line_state_in),
        .modem_state_in(modem_state_in),
        .fifo_ready_in(fifo_ready_in),
        .rdata_out(rdata_out),
        .rdata_oe_out(rdata_oe_out),
        .rx_pop_out(rx_pop_out),
        .tx_push_out(tx_push_out),
        .tx_byte_out(tx_byte_out),
        .fifo_ctrl_wr_out(fifo_ctrl_wr_out),
        .fifo_control_out(fifo_control_out),
        .interrupt_enables_out(interrupt_enables_out),
        .line_format_control_out(line_format_control_out),
        .modem_control_out(modem_control_out),
        .baud_divisor_out(baud_divisor_out),
        .enhanced_features_out(enhanced_features_out),
        .resume_char_one_out(resume_char_one_out),
        .resume_char_two_out(resume_char_two_out),
        .pause_char_one_out(pause_char_one_out),
        .pause_char_two_out(pause_char_two_out),
        .flow_halt_resume_levels_out(flow_halt_resume_levels_out),
        .fifo_threshold_levels_out(fifo_threshold_levels_out)
    );
    urs_engine_model i_urs_engine_model (.clk_in(clk_in), .nrst_in(nrst_in),
        .rx_pop_in(rx_pop_out), .rx_byte_out(rx_byte_in));
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    // protected bits keep the old value while enhanced mode is off
    function automatic logic [7:0] msk(input logic [7:0] o, n, p);
        return (o & p) | (n & ~p);
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] ex, got);
        n_tests++;
        if (got !== ex)
        begin
            mismatches++;
            $display("wrong value %s exp %h got %h", nm, ex, got);
        end
    endtask
    task automatic acc(input logic w, input logic [2:0] a,
                       input logic [7:0] d, input logic both);
        @(negedge clk_in);
        addr_in = a;
        wdata_in = d;
        channel_a_select_n_in = 0;
        channel_b_select_n_in = !both;
        repeat (3) @(negedge clk_in);
        wr_n_in = !w;
        rd_n_in = w;
        repeat (4) @(negedge clk_in);
        wr_n_in = 1;
        rd_n_in = 1;
        repeat (3) @(negedge clk_in);
        channel_a_select_n_in = 1;
        channel_b_select_n_in = 1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        acc(1, a, d, 0);
    endtask
    task automatic rc(input string nm, input logic [2:0] a,
                      input logic [7:0] ex, input logic both = 0);
        acc(0, a, 8'h00, both);
        chk(nm, ex, rdata_out);
    endtask
    initial
    begin
        forever #2.5 clk_in = !clk_in;
    end
    initial
    begin
        #20us;
        mismatches++;
        print_verdict();
    end
    initial
    begin
        ident_in = rnd();
        line_state_in = rnd();
        modem_state_in = rnd();
        fifo_ready_in = rnd();
        repeat (10) @(negedge clk_in);
        nrst_in = 1;
        wr(3'h3, 8'h03);
        rc("lcr", 3'h3, 8'h03);
        m = msk(8'h00, rnd(), 8'he0);
        wr(3'h4, m | 8'he0);
        rc("mcr", 3'h4, m);
        r = rnd();
        wr(3'h1, r);
        rc("ier", 3'h1, msk(8'h00, r, 8'hf0));
        s = rnd();
        wr(3'h7, s);
        rc("scratch", 3'h7, s);
        r = rx_byte_in;
        rc("rx", 3'h0, r);
        chk("next rx", r + 8'h35, rx_byte_in);
        r = rnd();
        wr(3'h0, r);
        chk("tx", r, tx_byte_out);
        rc("ident", 3'h2, ident_in);
        r = rnd();
        wr(3'h2, r);
        chk("fifo ctl", msk(8'h00, r, 8'h30), fifo_control_out);
        wr(3'h5, rnd());
        wr(3'h6, rnd());
        chk("mcr kept", m, modem_control_out);
        rc("line state", 3'h5, line_state_in);
        rc("modem state", 3'h6, modem_state_in);
        wr(3'h3, 8'h83);
        r = rnd();
        wr(3'h0, r);
        q = rnd();
        wr(3'h1, q);
        chk("div lo", r, baud_divisor_out[7:0]);
        chk("div hi", q, baud_divisor_out[15:8]);
        rc("div hi rd", 3'h1, q);
        rc("div lo rd", 3'h0, r);
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h10);
        chk("efr", 8'h10, enhanced_features_out);
        for (int i = 4; i < 8; i++)
            wr(i[2:0], 8'h10 + i[7:0]);
        chk("resume_char_one", 8'h14, resume_char_one_out);
        chk("resume_char_two", 8'h15, resume_char_two_out);
        chk("pause_char_one", 8'h16, pause_char_one_out);
        chk("pause_char_two", 8'h17, pause_char_two_out);
        chk("mcr under key", m, modem_control_out);
        rc("lcr key", 3'h3, 8'hbf);
        rc("efr rd", 3'h2, 8'h10);
        rc("pause_char_two rd", 3'h7, 8'h17);
        wr(3'h3, 8'h03);
        r = rnd();
        wr(3'h1, r);
        chk("ier enh", r, interrupt_enables_out);
        wr(3'h4, 8'h40);
        r = rnd();
        wr(3'h6, r);
        chk("tcr", r, flow_halt_resume_levels_out);
        q = rnd();
        wr(3'h7, q);
        chk("tlr", q, fifo_threshold_levels_out);
        rc("tcr rd", 3'h6, r);
        rc("tlr rd", 3'h7, q);
        wr(3'h3, 8'hbf);
        wr(3'h6, 8'h5c);
        chk("pause_char_one key", 8'h5c, pause_char_one_out);
        chk("tcr kept", r, flow_halt_resume_levels_out);
        wr(3'h3, 8'h03);
        wr(3'h4, 8'h04);
        rc("fifo rdy", 3'h7, fifo_ready_in & 8'h33, 1);
        rc("scratch one cs", 3'h7, s);
        print_verdict();
    end
endmodule // tb_top
